//--- core/vid444_link.sv
// Dual-link 4:4:4 video sender and serial receiver with an APB register file.
// Assumes pclk at 50 MHz; serial inputs and link clock come from another domain.
`timescale 1ns/1ps
`default_nettype none
module vid444_link (
   // Clock and reset.
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave.
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // Sample source.
   input  wire logic [9:0]           vid_a,
   input  wire logic [9:0]           vid_b,
   output logic                      vid_take,
   // Parallel links.
   output logic [9:0]                par_a_data,
   output logic [9:0]                par_b_data,
   output logic                      par_clk,
   // Serial links out.
   output logic                      ser_a,
   output logic                      ser_b,
   // Serial links in.
   input  wire logic                 rx_lclk,
   input  wire logic                 rx_ser_a,
   input  wire logic                 rx_ser_b,
   // Received stream.
   output logic [9:0]                rx_word_a,
   output logic [9:0]                rx_word_b,
   output logic                      rx_valid,
   output logic [2:0]                rx_fvh,
   output logic                      rx_flag_valid,
   output logic                      rx_dbl_err
);
   import vid444_pkg::*;

   // ==========================================================
   // Helpers.
   // Guard bits from field, vblank and horizontal flags.
   function automatic logic [3:0] guard_of(input logic f, input logic v, input logic h);
      return {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction : guard_of

   // Returns corrected {f,v,h} and a double-error bit from bits 9:2.
   function automatic logic [3:0] flag_fix(input logic [7:0] w);
      logic [3:0] syn;
      logic [2:0] fvh;
      logic       dbl;
      syn = w[3:0] ^ guard_of(w[6], w[5], w[4]);
      fvh = w[6:4];
      dbl = 1'b0;
      case (syn)
         4'h0, 4'h1, 4'h2, 4'h4, 4'h8: fvh = w[6:4];
         4'h7: fvh = w[6:4] ^ 3'h4;
         4'hB: fvh = w[6:4] ^ 3'h2;
         4'hD: fvh = w[6:4] ^ 3'h1;
         default: dbl = 1'b1;
      endcase
      return {fvh, dbl};
   endfunction : flag_fix

   // Keeps reserved codes out of the sample range.
   function automatic logic [9:0] clamp(input logic [9:0] s, input logic eight);
      logic [9:0] c;
      c = eight ? {s[9:2], 2'b00} : s;
      if (c[9:2] == TOP_ONES) begin
         c = eight ? {CLAMP_HI[9:2], 2'b00} : CLAMP_HI;
      end else if (c[9:2] == TOP_ZERO) begin
         c = eight ? {CLAMP_LO[9:2], 2'b00} : CLAMP_LO;
      end
      return c;
   endfunction : clamp

   // ==========================================================
   // APB slave with one wait state.
   logic [4:0]  ctrl_r;
   logic [11:0] active_r, blank_r;
   logic [15:0] dbl_cnt_r;
   logic        dbl_stk_r;
   logic [9:0]  line_r;
   logic        field_r, vblank_r;
   logic [1:0]  lock_w;
   logic        apb_wr, apb_hit, dbl_evt;
   logic [31:0] rd_nxt;

   assign apb_wr  = psel & penable & pready & pwrite;
   assign apb_hit = (paddr == REG_CTRL) | (paddr == REG_ACTIVE) | (paddr == REG_BLANK) |
                    (paddr == REG_STATUS) | (paddr == REG_RXSTAT);

   // Read mux; status words show the block's own timing and link state.
   always_comb begin
      case (paddr)
         REG_CTRL:   rd_nxt = {27'h0, ctrl_r};
         REG_ACTIVE: rd_nxt = {20'h0, active_r};
         REG_BLANK:  rd_nxt = {20'h0, blank_r};
         REG_STATUS: rd_nxt = {17'h0, lock_w, dbl_stk_r, field_r, vblank_r, line_r};
         REG_RXSTAT: rd_nxt = {13'h0, rx_fvh, dbl_cnt_r};
         default:    rd_nxt = 32'h0;
      endcase
   end

   // Answer one cycle after the access phase starts.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_nxt : 32'h0;
         pslverr <= psel & penable & ~pready & ~apb_hit;
      end
   end

   // Writable configuration; takes effect on the completing edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r   <= CTRL_RST;
         active_r <= ACTIVE_RST;
         blank_r  <= BLANK_RST;
      end else if (apb_wr) begin
         if (paddr == REG_CTRL) ctrl_r <= pwdata[4:0];
         if (paddr == REG_ACTIVE) active_r <= pwdata[11:0];
         if (paddr == REG_BLANK) blank_r <= pwdata[11:0];
      end
   end

   // Double-error monitor; a new error wins over a clearing write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbl_cnt_r <= 16'h0;
         dbl_stk_r <= 1'b0;
      end else if (dbl_evt) begin
         dbl_cnt_r <= (apb_wr && paddr == REG_RXSTAT) ? 16'h1 : dbl_cnt_r + 16'h1;
         dbl_stk_r <= 1'b1;
      end else if (apb_wr && paddr == REG_RXSTAT) begin
         dbl_cnt_r <= 16'h0;
         dbl_stk_r <= 1'b0;
      end
   end

   // ==========================================================
   // Transmit raster: word position within the line and line count.
   logic [3:0]  bit_cnt_r;
   logic [11:0] wpos_r, sav_start, act_start, last_pos, rel;
   logic [9:0]  line_nxt;
   logic        load, en, in_eav, in_blank, in_sav, in_act, f_nxt, v_nxt;
   logic [1:0]  slot, midx;
   logic [9:0]  flag_w;
   logic [9:0]  txw_nxt [2];
   logic [9:0]  txw_r   [2];

   assign en        = ctrl_r[CTL_EN];
   assign load      = bit_cnt_r == BIT_LAST;
   assign sav_start = MARK_LEN + blank_r;
   assign act_start = sav_start + MARK_LEN;
   assign last_pos  = act_start + active_r - 12'h001;
   assign in_eav    = wpos_r < MARK_LEN;
   assign in_blank  = !in_eav && wpos_r < sav_start;
   assign in_sav    = !in_eav && !in_blank && wpos_r < act_start;
   assign in_act    = !in_eav && !in_blank && !in_sav;
   assign rel       = in_act ? wpos_r - act_start : wpos_r - MARK_LEN;
   assign slot      = rel[1:0];
   assign midx      = in_eav ? wpos_r[1:0] : 2'(wpos_r - sav_start);
   assign line_nxt  = (line_r == (ctrl_r[CTL_625] ? L625_LAST : L525_LAST)) ?
                      LINE_FIRST : line_r + 10'h001;

   // Flags for the line about to begin, from the system's line table.
   always_comb begin
      if (ctrl_r[CTL_625]) begin
         v_nxt = line_nxt >= V625_S1 || line_nxt < V625_E1 ||
                 (line_nxt >= V625_S2 && line_nxt < V625_E2);
         f_nxt = line_nxt >= F625_2;
      end else begin
         v_nxt = line_nxt < V525_E1 || (line_nxt >= V525_S2 && line_nxt < V525_E2);
         f_nxt = line_nxt >= F525_2 || line_nxt < F525_1;
      end
   end

   // Bit counter free-runs so both links share one word clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_r <= 4'h0;
      end else begin
         bit_cnt_r <= load ? 4'h0 : bit_cnt_r + 4'h1;
      end
   end

   // Line advance; field and vblank move only at the line end marker.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wpos_r   <= 12'h0;
         line_r   <= LINE_FIRST;
         field_r  <= 1'b0;
         vblank_r <= 1'b1;
      end else if (!en) begin
         wpos_r <= 12'h0;
      end else if (load) begin
         if (wpos_r == last_pos) begin
            wpos_r   <= 12'h0;
            line_r   <= line_nxt;
            field_r  <= f_nxt;
            vblank_r <= v_nxt;
         end else begin
            wpos_r <= wpos_r + 12'h001;
         end
      end
   end

   // Flag word of the current marker, low two bits zero.
   assign flag_w = {1'b1, field_r, vblank_r, in_eav,
                    guard_of(field_r, vblank_r, in_eav), 2'b00};

   // Next word per link: markers, blanking fill or interleaved samples.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (!en) begin
            txw_nxt[i] = BLACK_LVL;
         end else if (in_eav || in_sav) begin
            case (midx)
               2'h0:    txw_nxt[i] = PRE_ONES;
               2'h3:    txw_nxt[i] = flag_w;
               default: txw_nxt[i] = PRE_ZERO;
            endcase
         end else if (in_blank || (i == 1 && slot[0] && !ctrl_r[CTL_KEY])) begin
            if (slot[0]) begin
               txw_nxt[i] = (i == 1) ? WHITE_LVL : BLACK_LVL;
            end else begin
               txw_nxt[i] = ctrl_r[CTL_YCC] ? ZERO_LVL : BLACK_LVL;
            end
         end else begin
            txw_nxt[i] = clamp((i == 0) ? vid_a : vid_b, ctrl_r[CTL_8BIT]);
         end
      end
   end

   // Sample request, high in the cycle whose edge takes vid_a and, outside key slots, vid_b.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vid_take <= 1'b0;
      end else begin
         vid_take <= en && bit_cnt_r == BIT_PRE && in_act;
      end
   end

   // Word clock: low for the first half word, rising midway.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_clk <= 1'b0;
      end else begin
         par_clk <= !load && bit_cnt_r >= CLK_RISE - 4'h1;
      end
   end

   // Per link: parallel word, scrambler and NRZI serialiser.
   logic [1:0] ser_w;
   generate
      for (genvar g = 0; g < 2; g++) begin : g_tx
         logic [9:0] sh_r;
         logic [8:0] scr_r;
         logic       nrz_r, sbit;
         assign sbit = sh_r[0] ^ scr_r[3] ^ scr_r[8];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               txw_r[g] <= BLACK_LVL;
               sh_r     <= 10'h0;
               scr_r    <= 9'h0;
               nrz_r    <= 1'b0;
            end else begin
               if (load) begin
                  txw_r[g] <= txw_nxt[g];
                  sh_r     <= txw_nxt[g];
               end else begin
                  sh_r <= {1'b0, sh_r[9:1]};
               end
               scr_r <= {scr_r[7:0], sbit};
               nrz_r <= nrz_r ^ sbit;
            end
         end
         assign ser_w[g] = nrz_r;
      end
   endgenerate

   assign par_a_data = txw_r[0];
   assign par_b_data = txw_r[1];
   assign ser_a      = ser_w[0];
   assign ser_b      = ser_w[1];

   // ==========================================================
   // Receive: synchronise link clock and data, sample on its rise.
   logic [2:0] lclk_s;
   logic [1:0] din_s1, din_s2;
   logic       lrise;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lclk_s <= 3'h0;
         din_s1 <= 2'h0;
         din_s2 <= 2'h0;
      end else begin
         lclk_s <= {lclk_s[1:0], rx_lclk};
         din_s1 <= {rx_ser_b, rx_ser_a};
         din_s2 <= din_s1;
      end
   end
   assign lrise = lclk_s[1] & ~lclk_s[2];

   logic [9:0] ln_word [2];
   logic [1:0] ln_vld, ln_fv, ln_dbl;
   logic [2:0] ln_fvh [2];

   generate
      for (genvar g = 0; g < 2; g++) begin : g_rx
         lane_st_t   st_r;
         logic       prev_r, d, bit_o, pre_hit;
         logic [8:0] hist_r;
         logic [29:0] sh_r, sh_nxt;
         logic [3:0] bc_r;
         logic       pend_r;
         logic [3:0] fix;
         assign d       = din_s2[g] ^ prev_r;
         assign bit_o   = d ^ hist_r[3] ^ hist_r[8];
         assign sh_nxt  = {bit_o, sh_r[29:1]};
         assign pre_hit = sh_nxt[9:2] == TOP_ONES && sh_nxt[19:12] == TOP_ZERO &&
                          sh_nxt[29:22] == TOP_ZERO;
         assign fix     = flag_fix(sh_nxt[29:22]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               st_r      <= ST_HUNT;
               prev_r    <= 1'b0;
               hist_r    <= 9'h0;
               sh_r      <= 30'h0;
               bc_r      <= 4'h0;
               pend_r    <= 1'b0;
               ln_word[g] <= 10'h0;
               ln_vld[g] <= 1'b0;
               ln_fv[g]  <= 1'b0;
               ln_dbl[g] <= 1'b0;
               ln_fvh[g] <= 3'h0;
            end else begin
               ln_vld[g] <= 1'b0;
               ln_fv[g]  <= 1'b0;
               ln_dbl[g] <= 1'b0;
               if (lrise) begin
                  prev_r <= din_s2[g];
                  hist_r <= {hist_r[7:0], d};
                  sh_r   <= sh_nxt;
                  bc_r   <= (bc_r == BIT_LAST) ? 4'h0 : bc_r + 4'h1;
                  if (st_r == ST_LOCK && bc_r == BIT_LAST) begin
                     ln_word[g] <= sh_nxt[29:20];
                     ln_vld[g]  <= 1'b1;
                     pend_r     <= 1'b0;
                     if (pend_r) begin
                        ln_fv[g]  <= ~fix[0];
                        ln_dbl[g] <= fix[0];
                        ln_fvh[g] <= fix[3:1];
                     end
                  end
                  if (pre_hit) begin
                     st_r   <= ST_LOCK;
                     bc_r   <= 4'h0;
                     pend_r <= 1'b1;
                  end
               end
            end
         end
         assign lock_w[g] = st_r == ST_LOCK;
      end
   endgenerate

   // Realign lanes: hold each word until its partner arrives.
   logic [9:0] hold_r [2];
   logic [1:0] hv_r;
   logic [1:0] have;
   assign have    = hv_r | ln_vld;
   assign dbl_evt = |ln_dbl;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_r[0]     <= 10'h0;
         hold_r[1]     <= 10'h0;
         hv_r          <= 2'h0;
         rx_word_a     <= 10'h0;
         rx_word_b     <= 10'h0;
         rx_valid      <= 1'b0;
         rx_fvh        <= 3'h0;
         rx_flag_valid <= 1'b0;
         rx_dbl_err    <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (&have) begin
            rx_word_a <= ln_vld[0] ? ln_word[0] : hold_r[0];
            rx_word_b <= ln_vld[1] ? ln_word[1] : hold_r[1];
            rx_valid  <= 1'b1;
            hv_r      <= 2'h0;
         end else begin
            for (int i = 0; i < 2; i++) begin
               if (ln_vld[i]) begin
                  hold_r[i] <= ln_word[i];
                  hv_r[i]   <= 1'b1;
               end
            end
         end
         rx_flag_valid <= ln_fv[0];
         if (ln_fv[0]) rx_fvh <= ln_fvh[0];
         rx_dbl_err    <= dbl_evt;
      end
   end

   // ==========================================================
   // Checks.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   marker_run_a: assert property (en && load && wpos_r == 12'h0 |=>
      txw_r[0] == PRE_ONES ##10 txw_r[0] == PRE_ZERO ##10 txw_r[0] == PRE_ZERO)
      else $error("marker preamble wrong");
   flag_bits_a: assert property (en && load && (in_eav || in_sav) && midx == 2'h3 |=>
      txw_r[0][9] && txw_r[0][1:0] == 2'b00 &&
      txw_r[0][5:2] == guard_of(txw_r[0][8], txw_r[0][7], txw_r[0][6]))
      else $error("flag word guard or fixed bits wrong");
   hflag_sense_a: assert property (en && load && (in_eav || in_sav) && midx == 2'h3 |=>
      txw_r[0][6] == $past(in_eav))
      else $error("horizontal flag wrong");
   fv_change_a: assert property ($changed(field_r) || $changed(vblank_r) |->
      $past(load) && wpos_r == 12'h0)
      else $error("field or vblank moved mid line");
   no_reserved_a: assert property (en && load && in_act |=>
      txw_r[0][9:2] != TOP_ONES && txw_r[0][9:2] != TOP_ZERO)
      else $error("reserved code in sample");
   blank_fill_a: assert property (en && load && in_blank && slot[0] |=>
      txw_r[0] == BLACK_LVL)
      else $error("blanking fill wrong");
   key_fill_a: assert property (en && load && in_act && slot[0] && !ctrl_r[CTL_KEY] |=>
      txw_r[1] == WHITE_LVL)
      else $error("key slot not peak white");
   clk_mid_a: assert property ($rose(par_clk) |-> bit_cnt_r == CLK_RISE)
      else $error("word clock not midway");
   data_edge_a: assert property ($changed(txw_r[0]) |-> bit_cnt_r == 4'h0)
      else $error("data changed off word boundary");

   lock_c: cover property ($rose(lock_w[0]));
   pair_c: cover property (rx_valid && rx_word_a == PRE_ONES);
   dbl_c:  cover property (rx_dbl_err);
   field_c: cover property ($rose(field_r));
endmodule : vid444_link
`default_nettype wire

//--- core/vid444_pkg.sv
// Constants shared by the dual-link 4:4:4 video interface.
// Assumes a single 50 MHz register clock; it depends on no other files.
package vid444_pkg;
   // ==========================================================
   // Word values on the link.
   localparam logic [9:0] PRE_ONES  = 10'h3FF;
   localparam logic [9:0] PRE_ZERO  = 10'h000;
   localparam logic [9:0] BLACK_LVL = 10'h040;
   localparam logic [9:0] ZERO_LVL  = 10'h200;
   localparam logic [9:0] WHITE_LVL = 10'h3AC;
   localparam logic [9:0] CLAMP_HI  = 10'h3FB;
   localparam logic [9:0] CLAMP_LO  = 10'h004;
   localparam logic [7:0] TOP_ONES  = 8'hFF;
   localparam logic [7:0] TOP_ZERO  = 8'h00;
   // ==========================================================
   // Word timing in register clocks: one serial bit per clock.
   localparam logic [3:0]  BIT_LAST  = 4'h9;
   localparam logic [3:0]  BIT_PRE   = 4'h8;
   localparam logic [3:0]  CLK_RISE  = 4'h5;
   localparam logic [11:0] MARK_LEN  = 12'h004;
   localparam int          PCLK_MHZ  = 50;
   localparam int          SKEW_NS   = 10;
   localparam int          SKEW_CYC  = ((SKEW_NS * PCLK_MHZ) / 1000 < 1) ? 1 :
                                       (SKEW_NS * PCLK_MHZ) / 1000;
   // ==========================================================
   // Register map and fields.
   localparam logic [7:0]  REG_CTRL   = 8'h00;
   localparam logic [7:0]  REG_ACTIVE = 8'h04;
   localparam logic [7:0]  REG_BLANK  = 8'h08;
   localparam logic [7:0]  REG_STATUS = 8'h0C;
   localparam logic [7:0]  REG_RXSTAT = 8'h10;
   localparam int          CTL_EN     = 0;
   localparam int          CTL_625    = 1;
   localparam int          CTL_YCC    = 2;
   localparam int          CTL_KEY    = 3;
   localparam int          CTL_8BIT   = 4;
   localparam logic [4:0]  CTRL_RST   = 5'h02;
   localparam logic [11:0] ACTIVE_RST = 12'h5A0;
   localparam logic [11:0] BLANK_RST  = 12'h358;
   // ==========================================================
   // Field and vertical blanking line numbers.
   localparam logic [9:0] L625_LAST = 10'h271, L525_LAST = 10'h20D;
   localparam logic [9:0] V625_S1 = 10'h270, V625_E1 = 10'h017;
   localparam logic [9:0] V625_S2 = 10'h137, V625_E2 = 10'h150, F625_2 = 10'h139;
   localparam logic [9:0] V525_E1 = 10'h014, V525_S2 = 10'h108;
   localparam logic [9:0] V525_E2 = 10'h11B, F525_1 = 10'h004, F525_2 = 10'h10A;
   localparam logic [9:0] LINE_FIRST = 10'h001;
   // Receive lane alignment states.
   typedef enum logic [0:0] {ST_HUNT = 1'b0, ST_LOCK = 1'b1} lane_st_t;
endpackage : vid444_pkg

//--- testbench/ser_src.sv
// Far-side serial sender model for the receive links A and B.
// Assumes the bench calls send_pair back to back within a frame.
`timescale 1ns/1ps
`default_nettype none
module ser_src (
   // Serial link out.
   output logic lclk,
   output logic sa,
   output logic sb
);
   logic [8:0] ha, hb;
   // ==========================================
   // Lane A starts high so the receiver must ignore polarity.
   initial begin
      lclk = 1'b0;
      sa   = 1'b1;
      sb   = 1'b0;
      ha   = 9'h000;
      hb   = 9'h000;
   end
   // Scramble, then NRZI, one pair of words LSB first at 160 ns a bit.
   task automatic send_pair(input logic [9:0] wa, input logic [9:0] wb);
      logic xa, xb;
      for (int i = 0; i < 10; i++) begin
         xa = wa[i] ^ ha[3] ^ ha[8];
         xb = wb[i] ^ hb[3] ^ hb[8];
         ha = {ha[7:0], xa};
         hb = {hb[7:0], xb};
         #45 sa = sa ^ xa;
         sb = sb ^ xb;
         #40 lclk = 1'b1;
         #75 lclk = 1'b0;
      end
   endtask : send_pair
endmodule : ser_src
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the dual-link video block.
// Assumes ser_src as the far sender; registers reached over APB.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vid444_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, vid_take, par_clk;
   logic ser_a, ser_b, rx_lclk, rx_ser_a, rx_ser_b, rx_valid, rx_flag_valid;
   logic rx_dbl_err, pc_d;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0]  vid_a, vid_b, par_a_data, par_b_data, rx_word_a, rx_word_b, la, lb;
   logic [2:0]  rx_fvh;
   logic [9:0]  qa[$], qb[$];
   int n_errors = 0, cmp_count = 0, n_fv = 0, n_dbl = 0, n_take = 0;
   vid444_link dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .vid_a(vid_a), .vid_b(vid_b), .vid_take(vid_take), .par_a_data(par_a_data),
      .par_b_data(par_b_data), .par_clk(par_clk), .ser_a(ser_a), .ser_b(ser_b),
      .rx_lclk(rx_lclk), .rx_ser_a(rx_ser_a), .rx_ser_b(rx_ser_b), .rx_word_a(rx_word_a),
      .rx_word_b(rx_word_b), .rx_valid(rx_valid), .rx_fvh(rx_fvh),
      .rx_flag_valid(rx_flag_valid), .rx_dbl_err(rx_dbl_err));
   ser_src src (.lclk(rx_lclk), .sa(rx_ser_a), .sb(rx_ser_b));
   // ==========================================
   // Clock, and a watchdog far beyond the expected run.
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      #400000;
      n_errors++;
      close_out();
   end
   // Word capture at each word clock rise, receive pulse counting.
   always @(posedge pclk) begin
      pc_d <= par_clk;
      if (par_clk === 1'b1 && pc_d === 1'b0) begin
         qa.push_back(par_a_data);
         qb.push_back(par_b_data);
      end
      if (rx_flag_valid === 1'b1) n_fv <= n_fv + 1;
      if (rx_dbl_err === 1'b1) n_dbl <= n_dbl + 1;
      if (vid_take === 1'b1) n_take <= n_take + 1;
      if (rx_valid === 1'b1) begin
         la <= rx_word_a;
         lb <= rx_word_b;
      end
   end
   // ==========================================
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [9:0] fw(input logic [2:0] x);
      return {1'b1, x, x[1] ^ x[0], x[2] ^ x[0], x[2] ^ x[1], ^x, 2'b00};
   endfunction : fw
   // One APB transfer; waits for pready without assuming a count.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = pslverr === 1'b1 ? 32'hDEAD0000 : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic mark(input logic [9:0] f);
      src.send_pair(10'h3FF, 10'h3FF);
      src.send_pair(10'h000, 10'h000);
      src.send_pair(10'h000, 10'h000);
      src.send_pair(f, f);
      src.send_pair(10'h200, 10'h200);
      repeat (20) @(posedge pclk);
   endtask : mark
   // ==========================================
   task automatic t_regs();
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl_rst", {27'h0, CTRL_RST}, rd);
      apb(1'b0, REG_ACTIVE, 32'h0);
      chk("active_rst", {20'h0, ACTIVE_RST}, rd);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", 32'hDEAD0000, rd);
   endtask : t_regs
   task automatic t_tx();
      int ne, ns;
      ne = 0;
      ns = 0;
      apb(1'b1, REG_ACTIVE, 32'h8);
      apb(1'b1, REG_BLANK, 32'h4);
      apb(1'b1, REG_CTRL, 32'h7);
      while (qa.size() < 60) begin
         @(posedge pclk);
      end
      for (int i = 0; i + 7 < qa.size(); i++) begin
         if (qa[i] == 10'h3FF && qa[i+1] == 10'h000 && qa[i+2] == 10'h000) begin
            chk("mark_b", 32'h3FF, qb[i]);
            chk("flag", fw(qa[i+3][8:6]), qa[i+3]);
            if (qa[i+3][6]) begin
               ne++;
               chk("blank_a", ZERO_LVL, qa[i+4]);
               chk("blank_key", WHITE_LVL, qb[i+5]);
            end else begin
               ns++;
               chk("samp_a", CLAMP_HI, qa[i+4]);
               chk("samp_b", 10'h155, qb[i+4]);
            end
         end
      end
      chk("both_marks", 1, ne > 0 && ns > 0);
      chk("take", 1, n_take > 0);
   endtask : t_tx
   task automatic t_rx();
      repeat (3) src.send_pair(10'h200, 10'h200);
      mark(fw(3'b011));
      src.send_pair(10'h123, 10'h2AA);
      repeat (20) @(posedge pclk);
      chk("fvh", 3'b011, rx_fvh);
      chk("word_a", 10'h123, la);
      chk("word_b", 10'h2AA, lb);
      mark(fw(3'b101) ^ 10'h100);
      chk("fvh_fix", 3'b101, rx_fvh);
      mark(fw(3'b010) ^ 10'h180);
      chk("n_fv", 2, n_fv);
      chk("n_dbl", 1, n_dbl);
      apb(1'b0, REG_RXSTAT, 32'h0);
      chk("dbl_cnt", 1, rd[15:0]);
   endtask : t_rx
   task automatic close_out();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   // Main sequence after an 8-cycle reset.
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      vid_a = 10'h3FF;
      vid_b = 10'h155;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_tx();
      t_rx();
      close_out();
   end
endmodule : tb_top
`default_nettype wire
